// >>> fsw_defines.svh
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH
`define FSW_OP_RDSR 8'h05
`define FSW_OP_WPC 8'h06
`define FSW_OP_WDIS 8'h04
`define FSW_OP_WSC 8'h01
`define FSW_OP_PROG 8'h02
`define FSW_OP_SE 8'h20
`define FSW_OP_BE32 8'h52
`define FSW_OP_BE64 8'hD8
`define FSW_OP_CE1 8'hC7
`define FSW_OP_CE2 8'h60
`define FSW_OP_SLEEP 8'hB9
`define FSW_OP_WAKE 8'hAB
`define FSW_BIT_LOCK 7
`define FSW_BIT_WPL 1
`define FSW_BIT_BUSY 0
`define FSW_NV_MASK 8'h9C
`define FSW_SW_RESET 8'h00
`define FSW_LIM_1 24'h07DFFF
`define FSW_LIM_2 24'h07BFFF
`define FSW_LIM_3 24'h077FFF
`define FSW_LIM_4 24'h06FFFF
`define FSW_LIM_5 24'h05FFFF
`define FSW_LIM_6 24'h03FFFF
`define FSW_LIM_7 24'h07FFFF
`define FSW_CLK_MHZ 40
`define FSW_PUW_US 100
`define FSW_PUW_CYC (`FSW_PUW_US * `FSW_CLK_MHZ)
`define FSW_T_WSR 32'd400
`define FSW_T_PROG 32'd800
`define FSW_T_SE 32'd1600
`define FSW_T_BE 32'd3200
`define FSW_T_CE 32'd6400
`endif

// >>> fsw_pkg.sv
package fsw_pkg;
    typedef enum logic [1:0] {
        FSW_IDLE = 2'b00,
        FSW_BUSY = 2'b01
    } fsw_state_t;
    typedef struct packed {
        logic lock;
        logic [1:0] rsvd;
        logic [2:0] guard;
        logic wpl;
        logic busy;
    } fsw_status_t;
endpackage

// >>> fsw_status_protect.sv
`timescale 1ns/1ps
`include "fsw_defines.svh"
// Contract
// - Busy and write-permit bits are internal only, never taken from host data.
// - Only the write-permit command 06h sets the write-permit latch.
// - Busy reads one while program, erase or status write runs.
// - While busy, every command except status read is discarded.
// - Busy returns to zero when the internal operation finishes.
// - Latch clears at reset and after disable, program, erase, status write.
// - Bits 4:2 are guard bits, default zero; bits 6:5 reserved zero.
// - Bit 7 is the lock bit; at one the guard pin may protect.
// - Lock one and guard pin low block status writes entirely.
// - Status write never loads busy or write-permit latch bits from host data.
// - Status write only takes effect after a preceding write-permit.
// - Write, program, erase ignored unless select rises on byte boundary.
// - During internal reset no command is recognised at all.
// - After reset, write-type commands rejected for power-up write delay.
// - Program, erase and status write rejected while latch is zero.
// - In deep sleep only the wake command ABh is obeyed.
// - Guard codes map to fixed lower ranges starting at address zero.
// - Program or erase into a guarded range is refused.
// - Status read returns status byte repeatedly, MSB first, until deselect.
module fsw_status_protect
    import fsw_pkg::*;
#(
    parameter int unsigned PUW_CYC = `FSW_PUW_CYC,
    parameter int unsigned T_WSR = `FSW_T_WSR,
    parameter int unsigned T_PROG = `FSW_T_PROG,
    parameter int unsigned T_SE = `FSW_T_SE,
    parameter int unsigned T_BE = `FSW_T_BE,
    parameter int unsigned T_CE = `FSW_T_CE
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic sdi,
    input wire logic guard_pin_n,
    output logic sdo,
    output logic sdo_oe_n,
    output logic [7:0] status_word,
    output logic op_start,
    output logic [7:0] op_code,
    output logic [23:0] op_addr,
    output logic op_refused
);
    // Pins pass two flops; the third stage of clock and select finds edges.
    logic [2:0] sclk_s_ff, sel_s_ff;
    logic [1:0] sdi_s_ff, wp_s_ff;
    always_ff @(posedge mclk) begin
        sclk_s_ff <= {sclk_s_ff[1:0], sclk};
        sel_s_ff <= {sel_s_ff[1:0], sel_n};
        sdi_s_ff <= {sdi_s_ff[0], sdi};
        wp_s_ff <= {wp_s_ff[0], guard_pin_n};
    end
    wire sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2];
    wire sclk_fall = ~sclk_s_ff[1] & sclk_s_ff[2];
    wire sel_act = ~sel_s_ff[1];
    wire sel_start = ~sel_s_ff[1] & sel_s_ff[2];
    wire sel_end = sel_s_ff[1] & ~sel_s_ff[2];

    fsw_status_t stat_ff;
    fsw_state_t state_ff;
    logic [31:0] busy_cnt_ff;
    logic [31:0] puw_cnt_ff;
    logic sleep_ff;
    logic [5:0] bit_cnt_ff;
    logic [7:0] cmd_ff;
    logic [31:0] shift_ff;
    logic [2:0] out_idx_ff;

    // Power-up write delay counter; no command is seen during reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            puw_cnt_ff <= 32'h0;
        end else if (puw_cnt_ff < PUW_CYC) begin
            puw_cnt_ff <= puw_cnt_ff + 32'h1;
        end
    end
    wire puw_done = (puw_cnt_ff >= PUW_CYC);

    // Serial input shifter. Bits counted from select fall to select rise.
    always_ff @(posedge mclk) begin
        if (srst) begin
            bit_cnt_ff <= 6'h0;
            shift_ff <= 32'h0;
            cmd_ff <= 8'h00;
        end else if (sel_start) begin
            bit_cnt_ff <= 6'h0;
        end else if (sel_act && sclk_rise) begin
            shift_ff <= {shift_ff[30:0], sdi_s_ff[1]};
            // Past 56 bits only the byte phase is kept, so long programs
            // are still judged on their byte boundary.
            if (bit_cnt_ff[5:3] != 3'h7) begin
                bit_cnt_ff <= bit_cnt_ff + 6'h1;
            end else begin
                bit_cnt_ff <= {3'h7, bit_cnt_ff[2:0] + 3'h1};
            end
            if (bit_cnt_ff == 6'h07) begin
                cmd_ff <= {shift_ff[6:0], sdi_s_ff[1]};
            end
        end
    end

    wire byte_ok = (bit_cnt_ff[2:0] == 3'h0);
    wire [7:0] op = cmd_ff;
    wire [23:0] addr = shift_ff[23:0];
    wire is_erase = (op == `FSW_OP_SE) || (op == `FSW_OP_BE32) ||
        (op == `FSW_OP_BE64);
    wire is_chip = (op == `FSW_OP_CE1) || (op == `FSW_OP_CE2);
    wire is_prog = (op == `FSW_OP_PROG);

    logic [23:0] lim;
    always_comb begin
        unique case (stat_ff.guard)
            3'h0: lim = 24'h0;
            3'h1: lim = `FSW_LIM_1;
            3'h2: lim = `FSW_LIM_2;
            3'h3: lim = `FSW_LIM_3;
            3'h4: lim = `FSW_LIM_4;
            3'h5: lim = `FSW_LIM_5;
            3'h6: lim = `FSW_LIM_6;
            3'h7: lim = `FSW_LIM_7;
        endcase
    end
    // Program address is the first address, captured at bit 32.
    logic [23:0] tgt_ff;
    always_ff @(posedge mclk) begin
        if (srst) begin
            tgt_ff <= 24'h0;
        end else if (sel_act && sclk_rise && bit_cnt_ff == 6'h1F) begin
            tgt_ff <= {shift_ff[22:0], sdi_s_ff[1]};
        end
    end
    // Chip erase spans every block, so any nonzero guard code refuses it.
    wire [23:0] eaddr = is_prog ? tgt_ff : addr;
    wire guarded = (stat_ff.guard != 3'h0) &&
        (is_chip || eaddr <= lim);
    wire hw_lock = stat_ff.lock & ~wp_s_ff[1];

    // Command acceptance, evaluated once at the end of a frame.
    wire frame_ok = sel_end && bit_cnt_ff >= 6'h08 && byte_ok &&
        state_ff == FSW_IDLE;
    wire awake = ~sleep_ff | (op == `FSW_OP_WAKE);
    wire do_wpc = frame_ok && awake && puw_done &&
        op == `FSW_OP_WPC && bit_cnt_ff == 6'h08;
    wire do_wdis = frame_ok && awake && op == `FSW_OP_WDIS;
    wire do_wsr = frame_ok && awake && puw_done && stat_ff.wpl &&
        op == `FSW_OP_WSC && bit_cnt_ff == 6'h10 && !hw_lock;
    wire len_ok = is_chip ? (bit_cnt_ff == 6'h08) :
        is_erase ? (bit_cnt_ff == 6'h20) : (bit_cnt_ff >= 6'h28);
    wire wr_cmd = is_prog || is_erase || is_chip;
    wire do_arr = frame_ok && awake && puw_done && stat_ff.wpl &&
        wr_cmd && len_ok && !guarded;

    logic [31:0] dur;
    always_comb begin
        if (do_wsr) dur = T_WSR;
        else if (is_prog) dur = T_PROG;
        else if (op == `FSW_OP_SE) dur = T_SE;
        else if (is_chip) dur = T_CE;
        else dur = T_BE;
    end

    // Busy state machine with per-operation duration.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= FSW_IDLE;
            busy_cnt_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                FSW_IDLE: begin
                    if (do_wsr || do_arr) begin
                        state_ff <= FSW_BUSY;
                        busy_cnt_ff <= dur;
                    end
                end
                FSW_BUSY: begin
                    if (busy_cnt_ff <= 32'h1) begin
                        state_ff <= FSW_IDLE;
                    end
                    busy_cnt_ff <= busy_cnt_ff - 32'h1;
                end
                default: state_ff <= FSW_IDLE;
            endcase
        end
    end

    logic nxt_busy;
    // Status word; busy and latch driven only by control logic.
    always_ff @(posedge mclk) begin
        if (srst) begin
            stat_ff <= `FSW_SW_RESET;
        end else begin
            stat_ff.busy <= nxt_busy;
            if (do_wpc) begin
                stat_ff.wpl <= 1'b1;
            end else if (do_wdis || do_wsr || do_arr) begin
                stat_ff.wpl <= 1'b0;
            end
            if (do_wsr) begin
                stat_ff.lock <= shift_ff[`FSW_BIT_LOCK];
                stat_ff.guard <= shift_ff[4:2];
            end
            stat_ff.rsvd <= 2'h0;
        end
    end
    always_comb begin
        nxt_busy = (state_ff == FSW_BUSY && busy_cnt_ff > 32'h1) ||
            do_wsr || do_arr;
    end

    // Sleep is entered from a clean one-byte frame and left only by wake or reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sleep_ff <= 1'b0;
        end else if (frame_ok && bit_cnt_ff == 6'h08) begin
            if (op == `FSW_OP_WAKE) sleep_ff <= 1'b0;
            else if (op == `FSW_OP_SLEEP && !sleep_ff) sleep_ff <= 1'b1;
        end
    end

    // Status read output: byte repeats MSB first on falling edges.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
            out_idx_ff <= 3'h7;
        end else if (!sel_act) begin
            sdo_oe_n <= 1'b1;
            out_idx_ff <= 3'h7;
        end else if (sclk_fall && bit_cnt_ff >= 6'h08 &&
            cmd_ff == `FSW_OP_RDSR && !sleep_ff) begin
            sdo_oe_n <= 1'b0;
            sdo <= stat_ff[out_idx_ff];
            out_idx_ff <= out_idx_ff - 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_word <= 8'h00;
            op_start <= 1'b0;
            op_code <= 8'h00;
            op_addr <= 24'h0;
            op_refused <= 1'b0;
        end else begin
            status_word <= stat_ff;
            op_start <= do_arr;
            // Refusals of status writes are reported as well.
            op_refused <= frame_ok && (wr_cmd || op == `FSW_OP_WSC) &&
                !do_arr && !do_wsr;
            if (do_arr) begin
                op_code <= op;
                op_addr <= eaddr;
            end
        end
    end

    chk_busy_hold: assert property (
        @(posedge mclk) disable iff (srst)
        state_ff == FSW_BUSY |-> stat_ff.busy)
        else $error("busy flag low during operation");
    chk_busy_clear: assert property (
        @(posedge mclk) disable iff (srst)
        $fell(state_ff == FSW_BUSY) |-> ##1 !stat_ff.busy)
        else $error("busy flag stuck");
    chk_wpl_set: assert property (
        @(posedge mclk) disable iff (srst)
        $rose(stat_ff.wpl) |-> $past(op) == `FSW_OP_WPC)
        else $error("latch set by wrong command");
    chk_wpl_clear: assert property (
        @(posedge mclk) disable iff (srst)
        do_arr |=> !stat_ff.wpl)
        else $error("latch not cleared");
    chk_no_busy_cmd: assert property (
        @(posedge mclk) disable iff (srst)
        state_ff == FSW_BUSY |-> !do_wsr && !do_arr && !do_wpc)
        else $error("command taken while busy");
    chk_lock_wsr: assert property (
        @(posedge mclk) disable iff (srst)
        hw_lock |-> !do_wsr)
        else $error("status write under lock");
    chk_wpl_needed: assert property (
        @(posedge mclk) disable iff (srst)
        (do_wsr || do_arr) |-> stat_ff.wpl)
        else $error("write without latch");
    chk_puw_block: assert property (
        @(posedge mclk) disable iff (srst)
        !puw_done |-> !do_wpc && !do_wsr && !do_arr)
        else $error("write during power-up delay");
    chk_rsvd_zero: assert property (
        @(posedge mclk) disable iff (srst)
        stat_ff.rsvd == 2'h0)
        else $error("reserved bits set");
    chk_wsr_volatile: assert property (
        @(posedge mclk) disable iff (srst)
        do_wsr |=> stat_ff.busy && !stat_ff.wpl)
        else $error("status write took volatile bits");
    chk_sleep_block: assert property (
        @(posedge mclk) disable iff (srst)
        (sleep_ff && op != `FSW_OP_WAKE) |-> !do_wpc && !do_wsr && !do_arr)
        else $error("command obeyed in sleep");
    chk_guard_refuse: assert property (
        @(posedge mclk) disable iff (srst)
        do_arr |-> !guarded)
        else $error("guarded range accepted");
    chk_byte_frame: assert property (
        @(posedge mclk) disable iff (srst)
        (do_wpc || do_wsr || do_arr) |-> bit_cnt_ff[2:0] == 3'h0)
        else $error("command off byte boundary");
    chk_lock_keep: assert property (
        @(posedge mclk) disable iff (srst)
        hw_lock |=> $stable(stat_ff.lock) && $stable(stat_ff.guard))
        else $error("locked bits changed");
    chk_sdo_release: assert property (
        @(posedge mclk) disable iff (srst)
        !sel_act |=> sdo_oe_n)
        else $error("output driven while deselected");
    chk_wpl_source: assert property (
        @(posedge mclk) disable iff (srst)
        $rose(stat_ff.wpl) |-> $past(do_wpc))
        else $error("latch set without permit");
    chk_busy_done: assert property (
        @(posedge mclk) disable iff (srst)
        (state_ff == FSW_BUSY && busy_cnt_ff <= 32'h1) |=> !stat_ff.busy)
        else $error("busy flag not cleared at end");
    chk_reset_quiet: assert property (
        @(posedge mclk)
        srst |=> !op_start && !op_refused && stat_ff == `FSW_SW_RESET)
        else $error("activity during reset");
    chk_wdis_clear: assert property (
        @(posedge mclk) disable iff (srst)
        do_wdis |=> !stat_ff.wpl)
        else $error("latch kept after disable");
    chk_busy_freeze: assert property (
        @(posedge mclk) disable iff (srst)
        state_ff == FSW_BUSY |=> $stable(stat_ff.lock) && $stable(stat_ff.guard))
        else $error("status changed while busy");
    chk_guard_report: assert property (
        @(posedge mclk) disable iff (srst)
        (frame_ok && wr_cmd && guarded) |=> op_refused)
        else $error("guarded command not reported");
    chk_guard_none: assert property (
        @(posedge mclk) disable iff (srst)
        stat_ff.guard == 3'h0 |-> !guarded)
        else $error("range guarded with zero code");
endmodule

// >>> fsw_host_model.sv
`timescale 1ns/1ps
module fsw_host_model (
    output logic sclk,
    output logic sel_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    // Sends n bits of d MSB first in mode 0 and keeps the last 8 bits read.
    task automatic xfer(input logic [39:0] d, input int n,
        output logic [7:0] rx);
        rx = 8'h00;
        sel_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            sdi = d[39 - i];
            #100 sclk = 1'b1;
            rx = {rx[6:0], sdo};
            #100 sclk = 1'b0;
        end
        #100 sel_n = 1'b1;
        sdi = ~sdi;
        #100;
    endtask
endmodule

// >>> flash_status_write_protect_bench.sv
`timescale 1ns/1ps
module flash_status_write_protect_bench;
    import fsw_pkg::*;
    typedef struct packed {
        logic [39:0] d;
        logic [5:0] n;
        logic g;
        logic [7:0] st;
        logic [7:0] m;
        logic s;
        logic r;
        logic rv;
    } fsw_row_t;
    // Each write except the row 2 status write, sent after a disable, is preceded by a write-permit row.
    localparam fsw_row_t ROWS [24] = '{
        '{40'h0600000000, 6'd8, 1'b1, 8'h02, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0400000000, 6'd8, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h011C000000, 6'd16, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b1, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h02, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0107000000, 6'd16, 1'b1, 8'h04, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h06, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h2007E00000, 6'd32, 1'b1, 8'h04, 8'hFF, 1'b1, 1'b0, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h06, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h2007D00000, 6'd32, 1'b1, 8'h04, 8'hFD, 1'b0, 1'b1, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h06, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h2007E00000, 6'd33, 1'b1, 8'h04, 8'hFD, 1'b0, 1'b0, 1'b0},
        '{40'h0600000000, 6'd8, 1'b1, 8'h06, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h019C000000, 6'd16, 1'b1, 8'h9C, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0600000000, 6'd8, 1'b0, 8'h9E, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0100000000, 6'd16, 1'b0, 8'h9C, 8'hFD, 1'b0, 1'b1, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h9E, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'hC700000000, 6'd8, 1'b1, 8'h9C, 8'hFD, 1'b0, 1'b1, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h9E, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0100000000, 6'd16, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'hB900000000, 6'd8, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'hAB00000000, 6'd8, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0600000000, 6'd8, 1'b1, 8'h02, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{40'h0400000000, 6'd8, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1}
    };
    logic mclk, srst, sclk, sel_n, sdi, guard_pin_n, sdo, sdo_oe_n;
    logic op_start, op_refused;
    logic [7:0] status_word, op_code, rx;
    logic [23:0] op_addr;
    int mismatches, check_count, starts, refs, cyc, s0, r0, oe_low;
    fsw_status_protect #(.PUW_CYC(200), .T_WSR(10), .T_PROG(10),
        .T_SE(400), .T_CE(10)) fsw_status_protect_i (
        .mclk(mclk), .srst(srst), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
        .guard_pin_n(guard_pin_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .status_word(status_word), .op_start(op_start),
        .op_code(op_code), .op_addr(op_addr), .op_refused(op_refused));
    fsw_host_model fsw_host_model_i (.sclk(sclk), .sel_n(sel_n),
        .sdi(sdi), .sdo(sdo));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (op_start === 1'b1) starts++;
        if (op_refused === 1'b1) refs++;
        if (sdo_oe_n === 1'b0) oe_low++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [39:0] d, input int n);
        fsw_host_model_i.xfer(d, n, rx);
        repeat (4) @(negedge mclk);
    endtask
    // Waits a bounded time for busy to drop, then lets status settle.
    task automatic idle;
        int k;
        k = 0;
        while (status_word[0] !== 1'b0 && k < 1000) begin
            @(negedge mclk);
            k++;
        end
        repeat (4) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        guard_pin_n = 1'b1;
        repeat (16) @(negedge mclk);
        check(status_word, 8'h00);
        check(sdo_oe_n, 1'b1);
        srst = 1'b0;
        run(40'h0600000000, 8);
        check(status_word, 8'h00);
        repeat (200) @(negedge mclk);
        $display("test reset done");
        foreach (ROWS[i]) begin
            guard_pin_n = ROWS[i].g;
            s0 = starts;
            r0 = refs;
            run(ROWS[i].d, ROWS[i].n);
            idle();
            check(status_word & ROWS[i].m, ROWS[i].st);
            check(starts - s0, ROWS[i].s);
            if (ROWS[i].rv) check(refs - r0, ROWS[i].r);
            $display("test row %0d done", i);
        end
        run(40'h0600000000, 8);
        run(40'h2001000000, 32);
        check(op_code, 8'h20);
        check(op_addr, 24'h010000);
        run(40'h0600000000, 8);
        run(40'h0500000000, 24);
        check(rx, 8'h01);
        check(oe_low > 0, 1'b1);
        check(sdo_oe_n, 1'b1);
        idle();
        check(status_word, 8'h00);
        $display("test busy done");
        run(40'h0600000000, 8);
        run(40'h0207E000A5, 40);
        check(op_code, 8'h02);
        check(op_addr, 24'h07E000);
        idle();
        check(status_word, 8'h00);
        $display("test program done");
        srst = 1'b1;
        run(40'h0600000000, 8);
        srst = 1'b0;
        @(negedge mclk);
        check(status_word, 8'h00);
        run(40'h0600000000, 8);
        check(status_word, 8'h00);
        repeat (200) @(negedge mclk);
        run(40'h0600000000, 8);
        check(status_word, 8'h02);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
